/* design/cbu_defs.svh */
// Contract
// - upper byte E6 branches when negative set
// - upper byte E3 branches when carry clear
// - upper byte E7 branches when negative clear
// - upper byte E5 branches when overflow clear
// - upper byte E1 branches when zero clear
// - low byte is signed offset, doubled
// - taken: pc+2+2n, two cycles, second idle
// - offset added to already incremented pc
// - not taken: pc+2, one cycle, no write
`ifndef CBU_DEFS_SVH
`define CBU_DEFS_SVH
`define CBU_OP_NEG_SET 8'hE6
`define CBU_OP_CARRY_CLR 8'hE3
`define CBU_OP_NEG_CLR 8'hE7
`define CBU_OP_OVF_CLR 8'hE5
`define CBU_OP_ZERO_CLR 8'hE1
`define CBU_PC_STEP 21'h000002
`define CBU_PC_RESET 21'h000000
`define CBU_PH_WRITE 2'h3
`endif

/* design/cbu_pkg.sv */
`default_nettype none
package cbu_pkg;
	typedef struct packed {
		logic neg;
		logic ovf;
		logic zero;
		logic carry;
	} cbu_flags_t;
	typedef enum logic [1:0] {
		CBU_EXEC = 2'b00,
		CBU_IDLE = 2'b01
	} cbu_state_t;
	typedef struct packed {
		logic valid;
		logic [15:0] opcode;
	} cbu_instr_t;
endpackage : cbu_pkg
`default_nettype wire

/* design/cbu_phase_gen.sv */
`default_nettype none
// four-phase sequencer; o_q4 is a one-cycle enable closing each cycle
module cbu_phase_gen (
	input wire logic i_clk_sys, // system clock
	input wire logic i_rst, // sync reset
	output logic [1:0] o_phase, // current quarter phase
	output logic o_q4 // pulse in last phase
);
	`include "cbu_defs.svh"
	logic [1:0] phase_reg;
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			phase_reg <= 2'h0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
		end
	end
	assign o_phase = phase_reg;
	assign o_q4 = (phase_reg == `CBU_PH_WRITE);
endmodule : cbu_phase_gen
`default_nettype wire

/* design/cbu_branch_unit.sv */
`default_nettype none
module cbu_branch_unit #(
	parameter int PC_W = 21 // program counter width
) (
	input wire logic i_clk_sys, // system clock
	input wire logic i_rst, // sync reset, active high
	input wire cbu_pkg::cbu_instr_t i_instr, // fetched opcode, held a cycle
	input wire cbu_pkg::cbu_flags_t i_flags, // status from arithmetic unit
	input wire logic [PC_W-1:0] i_pc_inc, // pc already advanced
	output logic [PC_W-1:0] o_pc, // program counter
	output logic o_pc_wr, // pulse: pc loaded with target
	output logic o_taken, // pulse: branch taken
	output logic o_is_branch, // level: current op is ours
	output logic o_busy, // level: idle second cycle
	output logic o_done, // pulse: instruction completes
	output cbu_pkg::cbu_flags_t o_flags // status, passed unchanged
);
	import cbu_pkg::*;
	`include "cbu_defs.svh"

	// only the closing-phase pulse steers this unit; phase count unused
	logic q4;
	cbu_phase_gen u_phase (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.o_phase(),
		.o_q4(q4)
	);

	wire logic [7:0] op_hi = i_instr.opcode[15:8];
	wire logic [7:0] offs = i_instr.opcode[7:0];
	wire logic hit_neg_set = (op_hi == `CBU_OP_NEG_SET);
	wire logic hit_carry_clr = (op_hi == `CBU_OP_CARRY_CLR);
	wire logic hit_neg_clr = (op_hi == `CBU_OP_NEG_CLR);
	wire logic hit_ovf_clr = (op_hi == `CBU_OP_OVF_CLR);
	wire logic hit_zero_clr = (op_hi == `CBU_OP_ZERO_CLR);
	wire logic is_branch = i_instr.valid & (hit_neg_set | hit_carry_clr |
		hit_neg_clr | hit_ovf_clr | hit_zero_clr);
	wire logic cond = (hit_neg_set & i_flags.neg)
		| (hit_carry_clr & ~i_flags.carry)
		| (hit_neg_clr & ~i_flags.neg)
		| (hit_ovf_clr & ~i_flags.ovf)
		| (hit_zero_clr & ~i_flags.zero);
	// sign-extend then double; shift before add keeps pc even
	wire logic [PC_W-1:0] disp =
		{{(PC_W-9){offs[7]}}, offs, 1'b0};
	wire logic [PC_W-1:0] target = i_pc_inc + disp;

	cbu_state_t state_reg, state_next;
	logic [PC_W-1:0] pc_reg, pc_next;
	logic pc_wr_reg, taken_reg, busy_reg, done_reg, isb_reg;
	cbu_flags_t flags_reg;
	wire logic exec_q4 = q4 & (state_reg == CBU_EXEC);
	wire logic take = exec_q4 & is_branch & cond;

	always_comb begin
		state_next = state_reg;
		pc_next = pc_reg;
		unique case (state_reg)
			CBU_EXEC: begin
				if (exec_q4) begin
					// non-branch ops and not-taken: plain increment
					pc_next = take ? target : i_pc_inc;
					if (take) begin
						state_next = CBU_IDLE;
					end
				end
			end
			CBU_IDLE: begin
				if (q4) begin
					state_next = CBU_EXEC; // forced no-op cycle
				end
			end
			default: begin
				state_next = CBU_EXEC;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state_reg <= CBU_EXEC;
			pc_reg <= PC_W'(`CBU_PC_RESET);
			pc_wr_reg <= 1'b0;
			taken_reg <= 1'b0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			isb_reg <= 1'b0;
			flags_reg <= '0;
		end else begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			pc_wr_reg <= take;
			taken_reg <= take;
			busy_reg <= (state_next == CBU_IDLE);
			done_reg <= (exec_q4 & ~take) | (q4 & state_reg == CBU_IDLE);
			isb_reg <= is_branch;
			flags_reg <= i_flags;
		end
	end

	assign o_pc = pc_reg;
	assign o_pc_wr = pc_wr_reg;
	assign o_taken = taken_reg;
	assign o_busy = busy_reg;
	assign o_done = done_reg;
	assign o_is_branch = isb_reg;
	assign o_flags = flags_reg;
endmodule : cbu_branch_unit
`default_nettype wire

/* testbench/cbu_branch_unit_properties.sv */
`default_nettype none
module cbu_branch_unit_properties #(parameter int PC_W = 21) (
	input wire logic i_clk_sys, i_rst, o_pc_wr, o_taken, o_busy, o_done,
	input wire logic o_is_branch,
	input wire cbu_pkg::cbu_instr_t i_instr,
	input wire cbu_pkg::cbu_flags_t i_flags, o_flags,
	input wire logic [PC_W-1:0] i_pc_inc, o_pc
);
	timeunit 1ns;
	timeprecision 100ps;
	import cbu_pkg::*;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);
	wire [7:0] h = i_instr.opcode[15:8], n = i_instr.opcode[7:0];
	wire [PC_W-1:0] tgt = i_pc_inc + PC_W'({{(PC_W-9){n[7]}}, n, 1'b0});
	wire hit = i_instr.valid && (h == 8'hE6 ? i_flags.neg :
		h == 8'hE7 ? !i_flags.neg : h == 8'hE3 ? !i_flags.carry :
		h == 8'hE5 ? !i_flags.ovf : h == 8'hE1 && !i_flags.zero);
	wire ours = i_instr.valid && (h == 8'hE6 || h == 8'hE3 ||
		h == 8'hE7 || h == 8'hE5 || h == 8'hE1);
	isb_a: assert property
		(!$past(i_rst) |-> o_is_branch == $past(ours))
		else $error("branch decode wrong");
	pair_a: assert property (o_pc_wr == o_taken)
		else $error("pc write and taken differ");
	cond_a: assert property
		(o_taken |-> $past(hit)) else $error("taken on false flag");
	target_a: assert property
		(o_pc_wr |-> o_pc == $past(tgt)) else $error("bad target");
	idle_a: assert property
		(o_pc_wr |-> o_busy [*4] ##1 !o_busy && o_done) else $error("bad idle");
	skip_a: assert property
		(o_done && !$past(o_busy) |-> !$past(hit) && o_pc == $past(i_pc_inc))
		else $error("bad fall through");
	nowr_a: assert property (o_done |-> !o_pc_wr)
		else $error("write at finish");
	space_a: assert property (o_done |=> !o_done [*3])
		else $error("done too soon");
	// copy lags a clock, so the edge leaving reset still shows zero
	flags_a: assert property
		(!$past(i_rst) |-> o_flags == $past(i_flags)) else $error("flags moved");
	cover property (o_taken);
	cover property (o_done && !$past(o_busy));
	cover property ($fell(o_busy));
endmodule : cbu_branch_unit_properties
bind cbu_branch_unit cbu_branch_unit_properties #(.PC_W(PC_W)) i_props (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .o_pc_wr(o_pc_wr),
	.o_taken(o_taken), .o_busy(o_busy), .o_done(o_done),
	.o_is_branch(o_is_branch), .i_instr(i_instr), .i_flags(i_flags),
	.o_flags(o_flags), .i_pc_inc(i_pc_inc), .o_pc(o_pc));
`default_nettype wire

/* testbench/cbu_branch_unit_tb.sv */
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
	$display("[ERR] %0t %h %h", $time, a, b); end end
module cbu_branch_unit_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import cbu_pkg::*;
	logic i_clk_sys = 0, i_rst = 1;
	logic o_pc_wr, o_taken, o_is_branch, o_busy, o_done;
	cbu_instr_t i_instr = '0;
	cbu_flags_t i_flags = '0, o_flags;
	logic [20:0] i_pc_inc = 21'h000100, o_pc;
	int failures = 0, total_checks = 0;
	logic [7:0] op [5] = '{8'hE6, 8'hE3, 8'hE7, 8'hE5, 8'hE1};
	// flags that make each code branch; their inverse must not
	logic [3:0] tf [5] = '{4'h8, 4'hE, 4'h7, 4'hB, 4'hD};
	logic [7:0] off [5] = '{8'h80, 8'h7F, 8'hFF, 8'h01, 8'h00};
	cbu_branch_unit i_dut (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_instr(i_instr),
		.i_flags(i_flags), .i_pc_inc(i_pc_inc), .o_pc(o_pc),
		.o_pc_wr(o_pc_wr), .o_taken(o_taken), .o_is_branch(o_is_branch),
		.o_busy(o_busy), .o_done(o_done), .o_flags(o_flags));
	initial forever #12.5 i_clk_sys = ~i_clk_sys;
	task automatic step(input logic [15:0] c, input logic [3:0] f,
		input logic tk);
		logic [20:0] pc;
		logic ours;
		i_pc_inc += 21'h000024;
		pc = i_pc_inc + (tk ? {{12{c[7]}}, c[7:0], 1'b0} : 21'h000000);
		ours = 1'b0;
		foreach (op[i]) if (op[i] == c[15:8]) ours = 1'b1;
		i_instr = '{1'b1, c};
		i_flags = f;
		repeat (4) @(posedge i_clk_sys);
		#1;
		`CHK(o_taken, tk)
		`CHK(o_pc_wr, tk)
		`CHK(o_pc, pc)
		`CHK(o_flags, f)
		`CHK(o_is_branch, ours)
		`CHK(o_busy, tk)
		`CHK(o_done, ~tk)
		if (tk) begin
			repeat (4) @(posedge i_clk_sys);
			#1;
			`CHK(o_done, 1'b1)
			`CHK(o_busy, 1'b0)
			`CHK(o_pc_wr, 1'b0)
		end
	endtask : step
	task automatic t_taken();
		for (int k = 0; k < 5; k++) step({op[k], off[k]}, tf[k], 1'b1);
	endtask : t_taken
	task automatic t_not_taken();
		for (int k = 0; k < 5; k++) step({op[k], 8'h7F}, ~tf[k], 1'b0);
	endtask : t_not_taken
	task automatic t_foreign();
		step(16'hE2FF, 4'hF, 1'b0); // neighbouring code is not ours
	endtask : t_foreign
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (8) @(posedge i_clk_sys);
		#1;
		i_rst = 0;
		t_taken();
		t_not_taken();
		t_foreign();
		give_verdict();
	end
endmodule : cbu_branch_unit_tb
`default_nettype wire
